// ### rtl/dhwuc_pkg.sv
// Purpose: shared constants and types of the DAC host write/update control
// Assumes: 125 MHz system clock
// Notes: timing counts are derived from times in their own units
package dhwuc_pkg;
	// clock rate and documented times
	localparam int CLK_MHZ = 125;
	localparam int RESET_TIME_NS = 270000;
	localparam int CLEAR_TIME_NS = 35000;
	localparam int CALC_TIME_NS = 1000; // internal calculation time
	// reset and clear times round down; only the calculation time is held to one cycle minimum
	localparam int RESET_CYCLES = RESET_TIME_NS * CLK_MHZ / 1000;
	localparam int CLEAR_CYCLES = CLEAR_TIME_NS * CLK_MHZ / 1000;
	localparam int CALC_CYCLES = (CALC_TIME_NS * CLK_MHZ / 1000 < 1) ? 1 :
		CALC_TIME_NS * CLK_MHZ / 1000;
	localparam int TIMER_W = 16;

	// parallel word layout
	localparam int DATA_W = 12;
	localparam int CHAN_W = 5;
	localparam int REGSEL_W = 2;
	localparam int SER_W = 24;

	// register select encodings
	localparam logic [1:0] REGSEL_SPECIAL = 2'h0;
	localparam logic [1:0] REGSEL_GAIN = 2'h1;
	localparam logic [1:0] REGSEL_OFFSET = 2'h2;
	localparam logic [1:0] REGSEL_INPUT = 2'h3;

	// write queue
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW = 3;
	localparam int ENTRY_W = 1 + REGSEL_W + CHAN_W + DATA_W;

	// positions in the synchronised pin vector
	localparam int PIN_DATA_LO = 0;
	localparam int PIN_MODE_SEL = 9;  // data line 9: spi/i2c select
	localparam int PIN_SCLK = 10;     // data line 10: serial clock
	localparam int PIN_DIN = 11;      // data line 11: serial data in
	localparam int PIN_CHAN_LO = 12;
	localparam int PIN_REG_LO = 17;
	localparam int PIN_AB = 19;
	localparam int PIN_WR = 20;
	localparam int PIN_CS = 21;
	localparam int PIN_LOAD_OUTPUTS_STROBE_N = 22;
	localparam int PIN_CLR_N = 23;
	localparam int PIN_RESET_N = 24;
	localparam int PIN_IF_SEL = 25;
	localparam int PIN_FIFO_EN = 26;
	localparam int PIN_W = 27;

	// sequencer states
	typedef enum logic [2:0]
	{
		ST_POR = 3'h0,
		ST_IDLE = 3'h1,
		ST_CALC = 3'h2,
		ST_CLEAR = 3'h3,
		ST_RESET = 3'h4
	} dhwuc_state_t;
endpackage

// ### rtl/dhwuc_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk_sys
// Notes: the stable copy changes only when stages two and three agree
`timescale 1ns/1ps
module dhwuc_sync
#(
	parameter int W = 1
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] stable
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// stage1 feeds stage2 only, to let metastability settle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else
		begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// per-bit agreement filter
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			stable <= '0;
		else
		begin
			for (int i = 0; i < W; i++)
			begin
				if (stage2[i] == stage3[i])
					stable[i] <= stage3[i];
			end
		end
	end
endmodule

// ### rtl/dhwuc_ctrl.sv
// Purpose: host write path and output update control of a multichannel DAC
// Assumes: pins asynchronous; toggle mode and clear code from local logic
// Notes: reset and clear durations are parameters for short simulations
`timescale 1ns/1ps
module dhwuc_ctrl
#(
	parameter int RESET_CYCLES = dhwuc_pkg::RESET_CYCLES,
	parameter int CLEAR_CYCLES = dhwuc_pkg::CLEAR_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic interfaceSelect,
	input wire logic chipSelectN,
	input wire logic writeStrobe,
	input wire logic [dhwuc_pkg::DATA_W-1:0] parallelDataLines,
	input wire logic [dhwuc_pkg::CHAN_W-1:0] channelAddressLines,
	input wire logic [dhwuc_pkg::REGSEL_W-1:0] registerSelectLines,
	input wire logic abSelect,
	input wire logic loadOutputsStrobeN,
	input wire logic clearToCodeInputN,
	input wire logic resetInputN,
	input wire logic fifoEnablePin,
	input wire logic toggleModeEnable,
	input wire logic [dhwuc_pkg::DATA_W-1:0] clearCodeValue,
	output logic busyN,
	output logic interfaceEnabled,
	output logic fifoEnabled,
	output logic wrValid,
	output logic [dhwuc_pkg::CHAN_W-1:0] wrChannel,
	output logic [dhwuc_pkg::REGSEL_W-1:0] wrRegSelect,
	output logic [dhwuc_pkg::DATA_W-1:0] wrData,
	output logic wrBankB,
	output logic dacLoad,
	output logic activeBankB,
	output logic clearAll,
	output logic [dhwuc_pkg::DATA_W-1:0] clearCode,
	output logic regDefaults,
	output logic chainEnable,
	output logic [1:0] busAddress,
	output logic sdoOut,
	output logic sdoOeN,
	output logic [dhwuc_pkg::SER_W-1:0] serialWord,
	output logic serialWordValid
);
	localparam logic [dhwuc_pkg::TIMER_W-1:0] TIMER_ZERO = '0;
	localparam logic [dhwuc_pkg::TIMER_W-1:0] RESET_LOAD =
		dhwuc_pkg::TIMER_W'(RESET_CYCLES - 1);
	localparam logic [dhwuc_pkg::TIMER_W-1:0] CLEAR_LOAD =
		dhwuc_pkg::TIMER_W'(CLEAR_CYCLES - 1);
	localparam logic [dhwuc_pkg::TIMER_W-1:0] CALC_LOAD =
		dhwuc_pkg::TIMER_W'(dhwuc_pkg::CALC_CYCLES - 1);
	localparam logic [dhwuc_pkg::FIFO_AW:0] COUNT_FULL =
		(dhwuc_pkg::FIFO_AW + 1)'(dhwuc_pkg::FIFO_DEPTH);
	localparam logic [dhwuc_pkg::FIFO_AW:0] COUNT_ZERO = '0;
	localparam logic [dhwuc_pkg::FIFO_AW:0] COUNT_ONE =
		(dhwuc_pkg::FIFO_AW + 1)'(1);
	localparam logic [dhwuc_pkg::FIFO_AW-1:0] PTR_ONE =
		dhwuc_pkg::FIFO_AW'(1);

	logic [dhwuc_pkg::PIN_W-1:0] pinRaw;
	logic [dhwuc_pkg::PIN_W-1:0] pin;
	logic [dhwuc_pkg::PIN_W-1:0] pinPrev;
	dhwuc_pkg::dhwuc_state_t state;
	dhwuc_pkg::dhwuc_state_t next_state;
	logic [dhwuc_pkg::TIMER_W-1:0] timer;
	logic [dhwuc_pkg::TIMER_W-1:0] next_timer;
	logic [dhwuc_pkg::ENTRY_W-1:0] fifoMem [dhwuc_pkg::FIFO_DEPTH];
	logic [dhwuc_pkg::FIFO_AW-1:0] wrPtr;
	logic [dhwuc_pkg::FIFO_AW-1:0] rdPtr;
	logic [dhwuc_pkg::FIFO_AW:0] fifoCount;
	logic loadPending;
	logic [dhwuc_pkg::SER_W-1:0] shiftReg;
	logic serialMode;
	logic spiMode;
	logic i2cMode;
	logic ifaceOn;
	logic wrRise;
	logic ldacFall;
	logic clrFall;
	logic resetFall;
	logic sclkRise;
	logic sclkFall;
	logic csRise;
	logic pushReq;
	logic popNow;
	logic loadNow;
	logic seqDone;
	logic entryBank;

	// every asynchronous pin passes one shared synchroniser
	assign pinRaw = {fifoEnablePin, interfaceSelect, resetInputN,
		clearToCodeInputN, loadOutputsStrobeN, chipSelectN, writeStrobe,
		abSelect, registerSelectLines, channelAddressLines,
		parallelDataLines};

	dhwuc_sync #(.W(dhwuc_pkg::PIN_W)) pinSync
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pinIn(pinRaw),
		.stable(pin)
	);

	// previous copy for single edge detect
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pinPrev <= '0;
		else
			pinPrev <= pin;
	end

	// mode decode from synchronised straps
	assign serialMode = pin[dhwuc_pkg::PIN_IF_SEL];
	assign spiMode = serialMode & ~pin[dhwuc_pkg::PIN_MODE_SEL];
	assign i2cMode = serialMode & pin[dhwuc_pkg::PIN_MODE_SEL];
	assign ifaceOn = (state != dhwuc_pkg::ST_POR) &&
		(state != dhwuc_pkg::ST_RESET);

	// chip select low level enables the cycle
	assign wrRise = ~serialMode & ifaceOn & ~pin[dhwuc_pkg::PIN_CS] &
		pin[dhwuc_pkg::PIN_WR] & ~pinPrev[dhwuc_pkg::PIN_WR];
	assign ldacFall = ~pin[dhwuc_pkg::PIN_LOAD_OUTPUTS_STROBE_N] &
		pinPrev[dhwuc_pkg::PIN_LOAD_OUTPUTS_STROBE_N];
	assign clrFall = ~pin[dhwuc_pkg::PIN_CLR_N] &
		pinPrev[dhwuc_pkg::PIN_CLR_N];
	assign resetFall = ~pin[dhwuc_pkg::PIN_RESET_N] &
		pinPrev[dhwuc_pkg::PIN_RESET_N];
	assign sclkRise = pin[dhwuc_pkg::PIN_SCLK] &
		~pinPrev[dhwuc_pkg::PIN_SCLK];
	assign sclkFall = ~pin[dhwuc_pkg::PIN_SCLK] &
		pinPrev[dhwuc_pkg::PIN_SCLK];
	assign csRise = pin[dhwuc_pkg::PIN_CS] & ~pinPrev[dhwuc_pkg::PIN_CS];
	assign seqDone = (timer == TIMER_ZERO);

	// queue handshake; without the queue a write needs an idle device
	assign pushReq = wrRise && (fifoCount != COUNT_FULL) &&
		(fifoEnabled || ((state == dhwuc_pkg::ST_IDLE) &&
		(fifoCount == COUNT_ZERO)));
	assign popNow = (state == dhwuc_pkg::ST_IDLE) &&
		(fifoCount != COUNT_ZERO) && !resetFall && !clrFall;
	// loads wait for queued data so earlier writes are included
	assign loadNow = (state == dhwuc_pkg::ST_IDLE) &&
		(fifoCount == COUNT_ZERO) && (ldacFall || loadPending) &&
		!resetFall && !clrFall;

	// toggle mode takes bank from the shared pin
	assign entryBank = toggleModeEnable & pin[dhwuc_pkg::PIN_AB] &
		(pin[dhwuc_pkg::PIN_REG_LO +: dhwuc_pkg::REGSEL_W] ==
		dhwuc_pkg::REGSEL_INPUT);

	// sequencer: reset beats clear beats calculation
	always_comb
	begin
		next_state = state;
		next_timer = timer;
		case (state)
			dhwuc_pkg::ST_POR:
			begin
				if (seqDone)
					next_state = dhwuc_pkg::ST_IDLE;
				else
					next_timer = timer - 1'b1;
			end
			dhwuc_pkg::ST_RESET:
			begin
				// busy released when the count ends
				// edges during the sequence are not seen
				if (seqDone)
					next_state = dhwuc_pkg::ST_IDLE;
				else
					next_timer = timer - 1'b1;
			end
			dhwuc_pkg::ST_IDLE:
			begin
				if (popNow)
				begin
					next_state = dhwuc_pkg::ST_CALC;
					next_timer = CALC_LOAD;
				end
			end
			dhwuc_pkg::ST_CALC, dhwuc_pkg::ST_CLEAR:
			begin
				if (seqDone)
					next_state = dhwuc_pkg::ST_IDLE;
				else
					next_timer = timer - 1'b1;
			end
			default:
			begin
				next_state = dhwuc_pkg::ST_POR;
				next_timer = RESET_LOAD;
			end
		endcase
		// falling reset edge starts the reset sequence, as long as the power-on one
		if (resetFall && ifaceOn)
		begin
			next_state = dhwuc_pkg::ST_RESET;
			next_timer = RESET_LOAD;
		end
		// clear holds busy for its fixed time
		else if (clrFall && ifaceOn)
		begin
			next_state = dhwuc_pkg::ST_CLEAR;
			next_timer = CLEAR_LOAD;
		end
	end

	// state and timer registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= dhwuc_pkg::ST_POR;
			timer <= RESET_LOAD;
		end
		else
		begin
			state <= next_state;
			timer <= next_timer;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busyN <= 1'b0;
			interfaceEnabled <= 1'b0;
		end
		else
		begin
			busyN <= (next_state == dhwuc_pkg::ST_IDLE);
			interfaceEnabled <= (next_state != dhwuc_pkg::ST_POR) &&
				(next_state != dhwuc_pkg::ST_RESET);
		end
	end

	// queue enable strap caught at end of the power-on, reset and clear sequences
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			fifoEnabled <= 1'b0;
		else if (seqDone && ((state == dhwuc_pkg::ST_POR) ||
			(state == dhwuc_pkg::ST_RESET) ||
			(state == dhwuc_pkg::ST_CLEAR)))
			fifoEnabled <= pin[dhwuc_pkg::PIN_FIFO_EN] & ~serialMode;
	end

	// data word kept with msb on line eleven
	always_ff @(posedge clk_sys)
	begin
		if (pushReq)
			fifoMem[wrPtr] <= {entryBank,
				pin[dhwuc_pkg::PIN_REG_LO +: dhwuc_pkg::REGSEL_W],
				pin[dhwuc_pkg::PIN_CHAN_LO +: dhwuc_pkg::CHAN_W],
				pin[dhwuc_pkg::PIN_DATA_LO +: dhwuc_pkg::DATA_W]};
	end

	// queue pointers; a reset sequence flushes pending writes
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			fifoCount <= '0;
		end
		else if (next_state == dhwuc_pkg::ST_RESET)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			fifoCount <= '0;
		end
		else
		begin
			if (pushReq)
				wrPtr <= wrPtr + PTR_ONE;
			if (popNow)
				rdPtr <= rdPtr + PTR_ONE;
			if (pushReq && !popNow)
				fifoCount <= fifoCount + COUNT_ONE;
			else if (popNow && !pushReq)
				fifoCount <= fifoCount - COUNT_ONE;
		end
	end

	// channel and register fields to the register file
	// register select passed with the target encoding
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrValid <= 1'b0;
			wrBankB <= 1'b0;
			wrRegSelect <= '0;
			wrChannel <= '0;
			wrData <= '0;
		end
		else
		begin
			wrValid <= popNow;
			if (popNow)
				{wrBankB, wrRegSelect, wrChannel, wrData} <= fifoMem[rdPtr];
		end
	end

	// a load seen while busy waits for idle
	// loads during reset are dropped, clear wins over set
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			loadPending <= 1'b0;
		else if (!ifaceOn || next_state == dhwuc_pkg::ST_RESET)
			loadPending <= 1'b0;
		else if (ldacFall && !loadNow)
			loadPending <= 1'b1;
		else if (loadNow)
			loadPending <= 1'b0;
	end

	// toggle mode swaps output bank on each load
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dacLoad <= 1'b0;
			activeBankB <= 1'b0;
		end
		else
		begin
			dacLoad <= loadNow;
			if (next_state == dhwuc_pkg::ST_RESET)
				activeBankB <= 1'b0;
			else if (loadNow && toggleModeEnable)
				activeBankB <= ~activeBankB;
		end
	end

	// clear edge loads every channel with the code
	// reset edge returns registers to defaults
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clearAll <= 1'b0;
			clearCode <= '0;
			regDefaults <= 1'b0;
		end
		else
		begin
			clearAll <= (next_state == dhwuc_pkg::ST_CLEAR) &&
				(state != dhwuc_pkg::ST_CLEAR || clrFall);
			regDefaults <= resetFall && ifaceOn;
			if (clrFall && ifaceOn && !resetFall)
				clearCode <= clearCodeValue;
		end
	end

	// shared strobe pin becomes chain enable
	// shared pins form the i2c address
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chainEnable <= 1'b0;
			busAddress <= '0;
		end
		else
		begin
			chainEnable <= spiMode & pin[dhwuc_pkg::PIN_WR];
			busAddress <= i2cMode ?
				{pin[dhwuc_pkg::PIN_WR], pin[dhwuc_pkg::PIN_CS]} : 2'h0;
		end
	end

	// shift serial input on falling clock
	// drive serial output on rising clock
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shiftReg <= '0;
			sdoOut <= 1'b0;
			sdoOeN <= 1'b1;
			serialWord <= '0;
			serialWordValid <= 1'b0;
		end
		else
		begin
			// output only while framed, otherwise released
			sdoOeN <= ~(spiMode & ifaceOn & ~pin[dhwuc_pkg::PIN_CS]);
			serialWordValid <= spiMode & ifaceOn & csRise;
			if (spiMode && ifaceOn && !pin[dhwuc_pkg::PIN_CS])
			begin
				if (sclkFall)
					shiftReg <= {shiftReg[dhwuc_pkg::SER_W-2:0],
						pin[dhwuc_pkg::PIN_DIN]};
				if (sclkRise)
					sdoOut <= shiftReg[dhwuc_pkg::SER_W-1];
			end
			if (spiMode && ifaceOn && csRise)
				serialWord <= shiftReg;
		end
	end
endmodule

// ### bench/dhwuc_monitor.sv
// Purpose: port checker for the dac host write and update control
// Assumes: one clock domain, asynchronous active-low reset
// Notes: checks pulse shapes and sequence windows, no data model
`timescale 1ns/1ps
module dhwuc_monitor
#(
	parameter int RESET_CYCLES = 40,
	parameter int CLEAR_CYCLES = 20
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic toggleModeEnable,
	input wire logic busyN,
	input wire logic interfaceEnabled,
	input wire logic wrValid,
	input wire logic [4:0] wrChannel,
	input wire logic [1:0] wrRegSelect,
	input wire logic [11:0] wrData,
	input wire logic wrBankB,
	input wire logic dacLoad,
	input wire logic activeBankB,
	input wire logic clearAll,
	input wire logic regDefaults
);
	logic [15:0] porCnt;
	// cycles since release; saturates so it never wraps back to zero
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			porCnt <= 16'h0000;
		else if (porCnt != 16'hFFFF)
			porCnt <= porCnt + 16'h0001;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wr_pulse_a: assert property (wrValid |=> !wrValid)
		else $error("write pulse longer than one cycle");
	wr_busy_a: assert property (wrValid |-> !busyN)
		else $error("write issued without busy");
	load_idle_a: assert property (dacLoad |-> busyN)
		else $error("outputs loaded while busy");
	bank_swap_a: assert property (dacLoad |->
		(activeBankB != $past(activeBankB)) == $past(toggleModeEnable))
		else $error("bank swap does not follow toggle mode");
	wr_bank_a: assert property (wrValid && wrBankB |->
		wrRegSelect == dhwuc_pkg::REGSEL_INPUT)
		else $error("bank B write outside input data register");
	wr_hold_a: assert property (!wrValid |->
		$stable({wrChannel, wrRegSelect, wrData, wrBankB}))
		else $error("write fields changed without a write");
	clear_busy_a: assert property (clearAll |=> !busyN [*8])
		else $error("busy released early after clear");
	reset_seq_a: assert property (regDefaults |=>
		(!busyN && !interfaceEnabled) [*8])
		else $error("reset sequence not held busy");
	seq_quiet_a: assert property (!interfaceEnabled |->
		!dacLoad && !wrValid)
		else $error("activity while interface disabled");
	por_busy_a: assert property (porCnt < RESET_CYCLES |->
		!busyN && !interfaceEnabled)
		else $error("power-on sequence ended early");
	cover property (wrValid && wrBankB);
	cover property (dacLoad && activeBankB);
	cover property (regDefaults);
endmodule
bind dhwuc_ctrl dhwuc_monitor #(.RESET_CYCLES(RESET_CYCLES),
	.CLEAR_CYCLES(CLEAR_CYCLES)) u_mon (.clk_sys(clk_sys),
	.rst_n(rst_n), .toggleModeEnable(toggleModeEnable), .busyN(busyN),
	.interfaceEnabled(interfaceEnabled), .wrValid(wrValid),
	.wrChannel(wrChannel), .wrRegSelect(wrRegSelect), .wrData(wrData),
	.wrBankB(wrBankB), .dacLoad(dacLoad), .activeBankB(activeBankB),
	.clearAll(clearAll), .regDefaults(regDefaults));

// ### bench/dhwuc_host_model.sv
// Purpose: behavioural host driving the parallel pins of the controller
// Assumes: tasks called from the bench, one transfer at a time
// Notes: released lines show the inverse of their last value
`timescale 1ns/1ps
module dhwuc_host_model
(
	input wire logic clk_sys,
	input wire logic sdoOut,
	input wire logic sdoOeN,
	output logic chipSelectN = 1'b1,
	output logic writeStrobe = 1'b1,
	output logic [11:0] parallelDataLines = 12'h000,
	output logic [4:0] channelAddressLines = 5'h00,
	output logic [1:0] registerSelectLines = 2'h0,
	output logic abSelect = 1'b0
);
	// select set from cs, lines set, strobe raised after setup
	// eight clocks of setup and strobe low, above the two the agreement filter needs
	task automatic write(input logic cs, input logic [4:0] ch,
		input logic [1:0] rs, input logic [11:0] d, input logic ab);
		@(posedge clk_sys);
		chipSelectN <= cs;
		writeStrobe <= 1'b0;
		parallelDataLines <= d;
		channelAddressLines <= ch;
		registerSelectLines <= rs;
		abSelect <= ab;
		repeat (8) @(posedge clk_sys);
		writeStrobe <= 1'b1;
	endtask
	// deselect; lines no longer hold their value
	task automatic idle();
		@(posedge clk_sys);
		chipSelectN <= 1'b1;
		parallelDataLines <= ~parallelDataLines;
		channelAddressLines <= ~channelAddressLines;
		registerSelectLines <= ~registerSelectLines;
		abSelect <= ~abSelect;
	endtask
	// static levels for the serial modes, mode select on data line 9
	task automatic levels(input logic cs, input logic wr, input logic d9);
		@(posedge clk_sys);
		chipSelectN <= cs;
		writeStrobe <= wr;
		parallelDataLines <= {2'h0, d9, 9'h000};
	endtask
	// din set with the rise, held over the fall that samples it
	// sdo read late in the high phase, once the device has settled it
	task automatic spiFrame(input logic [23:0] w, output logic [23:0] got,
		output logic oeLow);
		oeLow = 1'b1;
		@(posedge clk_sys);
		chipSelectN <= 1'b0;
		repeat (8) @(posedge clk_sys);
		for (int i = 23; i >= 0; i--)
		begin
			parallelDataLines <= {w[i], 1'b1, 10'h000};
			repeat (8) @(posedge clk_sys);
			got[i] = sdoOut;
			oeLow = oeLow & ~sdoOeN;
			parallelDataLines <= {w[i], 1'b0, 10'h000};
			repeat (8) @(posedge clk_sys);
		end
		chipSelectN <= 1'b1;
	endtask
endmodule

// ### bench/tb_top.sv
// Purpose: self-checking bench for the dac host write and update control
// Assumes: short reset and clear counts, fifo strap high at first
// Notes: each scenario judges its own results before returning
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin \
	nFail++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	localparam int RST_CYC = 40;
	localparam int CLR_CYC = 20;
	int nFail = 0;
	int checkCount = 0;
	logic clk_sys, rst_n, interfaceSelect, loadOutputsStrobeN;
	logic clearToCodeInputN, resetInputN, fifoEnablePin, toggleModeEnable;
	logic [11:0] clearCodeValue, parallelDataLines, wrData, clearCode;
	logic chipSelectN, writeStrobe, abSelect, busyN, interfaceEnabled;
	logic fifoEnabled, wrValid, wrBankB, dacLoad, activeBankB, clearAll;
	logic regDefaults, chainEnable;
	logic sdoOut, sdoOeN, serialWordValid;
	logic [23:0] serialWord;
	logic [4:0] channelAddressLines, wrChannel;
	logic [1:0] registerSelectLines, wrRegSelect, busAddress;
	dhwuc_host_model u_host (.clk_sys(clk_sys), .sdoOut(sdoOut),
		.sdoOeN(sdoOeN), .chipSelectN(chipSelectN),
		.writeStrobe(writeStrobe), .parallelDataLines(parallelDataLines),
		.channelAddressLines(channelAddressLines),
		.registerSelectLines(registerSelectLines), .abSelect(abSelect));
	dhwuc_ctrl #(.RESET_CYCLES(RST_CYC), .CLEAR_CYCLES(CLR_CYC)) u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .interfaceSelect(interfaceSelect),
		.chipSelectN(chipSelectN), .writeStrobe(writeStrobe),
		.parallelDataLines(parallelDataLines),
		.channelAddressLines(channelAddressLines),
		.registerSelectLines(registerSelectLines), .abSelect(abSelect),
		.loadOutputsStrobeN(loadOutputsStrobeN),
		.clearToCodeInputN(clearToCodeInputN), .resetInputN(resetInputN),
		.fifoEnablePin(fifoEnablePin), .toggleModeEnable(toggleModeEnable),
		.clearCodeValue(clearCodeValue), .busyN(busyN),
		.interfaceEnabled(interfaceEnabled), .fifoEnabled(fifoEnabled),
		.wrValid(wrValid), .wrChannel(wrChannel), .wrRegSelect(wrRegSelect),
		.wrData(wrData), .wrBankB(wrBankB), .dacLoad(dacLoad),
		.activeBankB(activeBankB), .clearAll(clearAll),
		.clearCode(clearCode), .regDefaults(regDefaults),
		.chainEnable(chainEnable), .busAddress(busAddress),
		.sdoOut(sdoOut), .sdoOeN(sdoOeN), .serialWord(serialWord),
		.serialWordValid(serialWordValid));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// bounded wait for a pulse; sampled 1 ns after the edge so it is settled
	task automatic waitFor(input int sel, input int lim, output bit hit);
		logic [4:0] v;
		hit = 0;
		for (int i = 0; i < lim && !hit; i++)
		begin
			@(posedge clk_sys);
			#1;
			v = {serialWordValid, regDefaults, clearAll, dacLoad, wrValid};
			hit = (v[sel] === 1'b1);
		end
	endtask
	task automatic waitIdle(output int n);
		n = 0;
		while (busyN !== 1'b1 && n < 2000)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask
	// active-low strobes: 0 load, 1 clear, 2 reset
	task automatic pin(input int sel, input logic v);
		@(posedge clk_sys);
		case (sel)
			0: loadOutputsStrobeN <= v;
			1: clearToCodeInputN <= v;
			default: resetInputN <= v;
		endcase
	endtask
	task automatic testPor();
		int n;
		waitIdle(n);
		`CHK("porLen", 1'b1, n >= RST_CYC && n <= RST_CYC + 3);
		`CHK("interfaceEnabled", 1'b1, interfaceEnabled);
		`CHK("fifoEnabled", 1'b1, fifoEnabled);
	endtask
	task automatic testWrite();
		bit hit;
		int n;
		for (int r = 0; r < 4; r++)
		begin
			u_host.write(1'b0, 5'h1F - 5'(r), 2'(r), 12'h801 ^ 12'(r), 1'b1);
			waitFor(0, 20, hit);
			`CHK("wrValid", 1'b1, hit);
			`CHK("wrChannel", 5'h1F - 5'(r), wrChannel);
			`CHK("wrRegSelect", 2'(r), wrRegSelect);
			`CHK("wrData", 12'h801 ^ 12'(r), wrData);
			`CHK("wrBankB", 1'b0, wrBankB);
			waitIdle(n);
			`CHK("idle", 1'b1, busyN);
		end
		u_host.write(1'b1, 5'h02, 2'h3, 12'h0FF, 1'b0);
		waitFor(0, 20, hit);
		`CHK("csHighWrite", 1'b0, hit);
		u_host.idle();
	endtask
	task automatic testToggle();
		bit hit;
		logic b;
		int n;
		toggleModeEnable <= 1'b1;
		u_host.write(1'b0, 5'h04, 2'h3, 12'h123, 1'b1);
		waitFor(0, 20, hit);
		`CHK("wrBankB", 1'b1, wrBankB);
		waitIdle(n);
		`CHK("idle", 1'b1, busyN);
		b = activeBankB;
		pin(0, 1'b0);
		waitFor(1, 20, hit);
		`CHK("dacLoad", 1'b1, hit);
		`CHK("activeBankB", ~b, activeBankB);
		pin(0, 1'b1);
		cyc(8);
		toggleModeEnable <= 1'b0;
	endtask
	// load arrives during the calculation and must wait for it
	task automatic testBusyLoad();
		bit hit;
		u_host.write(1'b0, 5'h07, 2'h3, 12'hABC, 1'b0);
		waitFor(0, 20, hit);
		// second write lands in the queue during the calculation
		u_host.write(1'b0, 5'h08, 2'h3, 12'h456, 1'b0);
		pin(0, 1'b0);
		waitFor(1, 60, hit);
		`CHK("loadEarly", 1'b0, hit);
		waitFor(1, 200, hit);
		`CHK("loadLate", 1'b1, hit);
		`CHK("busyN", 1'b1, busyN);
		`CHK("queuedData", 12'h456, wrData);
		pin(0, 1'b1);
		cyc(8);
	endtask
	task automatic testClear();
		bit hit;
		int n;
		clearCodeValue <= 12'h5A3;
		pin(1, 1'b0);
		waitFor(2, 20, hit);
		`CHK("clearAll", 1'b1, hit);
		`CHK("clearCode", 12'h5A3, clearCode);
		waitIdle(n);
		`CHK("clearLen", 1'b1, n >= CLR_CYC - 1 && n <= CLR_CYC + 2);
		pin(1, 1'b1);
		cyc(8);
	endtask
	// load falls inside the sequence; reset pin stays low after it
	task automatic testReset();
		bit hit;
		int n;
		fifoEnablePin <= 1'b0;
		pin(2, 1'b0);
		waitFor(3, 20, hit);
		`CHK("regDefaults", 1'b1, hit);
		`CHK("interfaceEnabled", 1'b0, interfaceEnabled);
		pin(0, 1'b0);
		waitIdle(n);
		`CHK("resetLen", 1'b1, n >= RST_CYC - 2 && n <= RST_CYC + 2);
		`CHK("fifoOff", 1'b0, fifoEnabled);
		waitFor(1, 20, hit);
		`CHK("ignoredLoad", 1'b0, hit);
		waitFor(3, 20, hit);
		`CHK("levelIgnored", 1'b0, hit);
		pin(0, 1'b1);
		pin(2, 1'b1);
		cyc(8);
	endtask
	// two frames: the second shifts the first word back out on sdo
	task automatic testSpi();
		bit hit;
		logic [23:0] got;
		logic oe;
		interfaceSelect <= 1'b1;
		u_host.levels(1'b1, 1'b1, 1'b0);
		cyc(10);
		u_host.spiFrame(24'hC35A96, got, oe);
		waitFor(4, 12, hit);
		`CHK("wordValid", 1'b1, hit);
		`CHK("serialWord", 24'hC35A96, serialWord);
		`CHK("sdoOeN", 1'b1, sdoOeN);
		u_host.spiFrame(24'h3C69A5, got, oe);
		waitFor(4, 12, hit);
		`CHK("serialWord2", 24'h3C69A5, serialWord);
		`CHK("sdoOut", 24'hC35A96, got);
		`CHK("sdoDriven", 1'b1, oe);
	endtask
	task automatic testSerial();
		interfaceSelect <= 1'b1;
		u_host.levels(1'b1, 1'b1, 1'b0);
		cyc(10);
		`CHK("chainEnable", 1'b1, chainEnable);
		u_host.levels(1'b1, 1'b0, 1'b1);
		cyc(10);
		`CHK("busAddress", 2'h1, busAddress);
		u_host.levels(1'b1, 1'b1, 1'b0);
		interfaceSelect <= 1'b0;
		cyc(10);
	endtask
	task automatic finalReport();
		if (nFail == 0 && checkCount > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// watchdog well beyond the few thousand cycles the scenarios need
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		nFail++;
		finalReport();
	end
	initial
	begin
		rst_n = 1'b0;
		interfaceSelect = 1'b0;
		loadOutputsStrobeN = 1'b1;
		clearToCodeInputN = 1'b1;
		resetInputN = 1'b1;
		fifoEnablePin = 1'b1;
		toggleModeEnable = 1'b0;
		clearCodeValue = 12'h000;
		cyc(4);
		rst_n <= 1'b1;
		testPor();
		testWrite();
		testToggle();
		testBusyLoad();
		testClear();
		testReset();
		testSpi();
		testSerial();
		finalReport();
	end
endmodule
